// ---- hw/multiproc_bus_request_reset.sv ----
`timescale 1ns/1ns
module multiproc_bus_request_reset #(
    parameter int          LOCK_CYCLES  = bus_req_pkg::LOCK_CYCLES,
    parameter logic [31:0] RESET_VECTOR = bus_req_pkg::RESET_VECTOR_DEFAULT
) (
    input  wire logic                                    ref_clk,
    input  wire logic                                    rst_b,
    input  wire logic [bus_req_pkg::BOOT_W-1:0]          boot_mode_select,
    input  wire logic [bus_req_pkg::INDEX_W-1:0]         processor_index,
    input  wire logic                                    rotating_priority_select,
    input  wire logic [bus_req_pkg::LINE_COUNT-1:0]      bus_request_lines_in,
    output bus_req_pkg::line_drive_t                     bus_request_lines_drv,
    input  wire logic                                    core_bus_req,
    output logic                                         bus_grant,
    output logic                                         core_reset_drive_b,
    output logic                                         core_run,
    output logic                                         fetch_start,
    output logic [31:0]                                  fetch_addr,
    output logic [bus_req_pkg::BOOT_W-1:0]               boot_mode
);

    localparam int NL   = bus_req_pkg::LINE_COUNT;
    localparam int CW   = $clog2(LOCK_CYCLES + 1);
    localparam logic [CW-1:0] LOCK_LAST = CW'(LOCK_CYCLES - 1);
    localparam logic [CW-1:0] LOCK_FULL = CW'(LOCK_CYCLES);

    // ****************************************************************
    // reset sequencing
    // ****************************************************************
    bus_req_pkg::phase_t phase_q;
    bus_req_pkg::phase_t phase_d;
    logic [CW-1:0]       lock_cnt_q;
    logic [CW-1:0]       lock_cnt_d;
    logic                lock_done;

    assign lock_done = (phase_q == bus_req_pkg::ST_LOCK)
                       && (lock_cnt_q == LOCK_LAST);
    assign lock_cnt_d = (phase_q == bus_req_pkg::ST_LOCK)
                        ? lock_cnt_q + 1'b1 : lock_cnt_q;

    always_comb
    begin
        case (phase_q)
            bus_req_pkg::ST_LOCK: phase_d = lock_done
                                  ? bus_req_pkg::ST_RUN
                                  : bus_req_pkg::ST_LOCK;
            bus_req_pkg::ST_RUN:  phase_d = bus_req_pkg::ST_RUN;
            default:              phase_d = bus_req_pkg::ST_LOCK;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            phase_q    <= bus_req_pkg::ST_LOCK;
            lock_cnt_q <= '0;
        end
        else
        begin
            phase_q    <= phase_d;
            lock_cnt_q <= lock_cnt_d;
        end
    end

    assign core_run = (phase_q == bus_req_pkg::ST_RUN);

    // reset out follows the core: low until the lock wait ends
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            core_reset_drive_b <= 1'b0;
        else
            core_reset_drive_b <= (phase_d == bus_req_pkg::ST_RUN);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            fetch_start <= 1'b0;
        else
            fetch_start <= lock_done;
    end

    // the vector is a constant; held in a flop so the port is registered
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            fetch_addr <= RESET_VECTOR;
    end

    // ****************************************************************
    // straps caught while reset is held
    // ****************************************************************
    logic [bus_req_pkg::INDEX_W-1:0] index_q;

    // the last value seen in reset wins; later pin changes are ignored
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            boot_mode <= boot_mode_select;
            index_q   <= processor_index;
        end
    end

    // ****************************************************************
    // own line decode
    // ****************************************************************
    logic [NL-1:0] own_sel;
    logic          solo;
    logic          own_valid;

    for (genvar g = 0; g < NL; g++)
    begin : g_sel
        assign own_sel[g] =
            (index_q == bus_req_pkg::INDEX_FIRST
                        + bus_req_pkg::INDEX_W'(g));
    end

    assign solo      = (index_q == bus_req_pkg::INDEX_SOLO);
    assign own_valid = |own_sel;

    // reserved codes drive nothing and never get the bus
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            bus_request_lines_drv.level  <= bus_req_pkg::LINES_IDLE;
            bus_request_lines_drv.enable <= bus_req_pkg::LINES_OFF;
        end
        else
        begin
            bus_request_lines_drv.level  <=
                ~(own_sel & {NL{core_run & core_bus_req}});
            bus_request_lines_drv.enable <=
                own_sel & {NL{phase_d == bus_req_pkg::ST_RUN}};
        end
    end

    // ****************************************************************
    // arbitration
    // ****************************************************************
    logic [NL-1:0]                 req_vec;
    logic [bus_req_pkg::LINE_W-1:0] ptr_q;
    logic [bus_req_pkg::LINE_W-1:0] ptr_d;
    logic [bus_req_pkg::LINE_W-1:0] ptr_eff;
    logic [bus_req_pkg::LINE_W-1:0] master_q;
    logic [bus_req_pkg::LINE_W-1:0] master_d;
    logic [bus_req_pkg::LINE_W-1:0] winner;
    logic                          master_vld_q;
    logic                          master_vld_d;
    logic                          keep;
    logic                          grant_d;

    function automatic logic [bus_req_pkg::LINE_W-1:0] pick(
        input logic [NL-1:0]                  req,
        input logic [bus_req_pkg::LINE_W-1:0] start
    );
        logic [bus_req_pkg::LINE_W-1:0] idx;
        logic                           found;
        pick  = start;
        found = 1'b0;
        for (int k = 0; k < NL; k++)
        begin
            idx = start + bus_req_pkg::LINE_W'(k);
            if (!found && req[idx])
            begin
                pick  = idx;
                found = 1'b1;
            end
        end
    endfunction : pick

    // every processor sees the same pins, so all pick the same master
    assign req_vec  = ~bus_request_lines_in;
    assign ptr_eff  = rotating_priority_select
                      ? ptr_d : bus_req_pkg::PTR_FIRST;
    assign winner   = pick(req_vec, ptr_eff);
    assign keep     = master_vld_q && req_vec[master_q];
    assign master_d = keep ? master_q : winner;
    assign master_vld_d = keep || (|req_vec);
    assign ptr_d    = (master_vld_q && !keep)
                      ? master_q + 1'b1 : ptr_q;
    assign grant_d  = core_run && core_bus_req
                      && (solo || (own_valid && master_vld_d
                                   && own_sel[master_d]));

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            ptr_q        <= bus_req_pkg::PTR_FIRST;
            master_q     <= bus_req_pkg::PTR_FIRST;
            master_vld_q <= 1'b0;
            bus_grant    <= 1'b0;
        end
        else
        begin
            ptr_q        <= ptr_d;
            master_q     <= master_d;
            master_vld_q <= master_vld_d;
            bus_grant    <= grant_d;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [CW-1:0] rel_cnt_q;
    logic [NL-1:0] below_own;

    // cycles since release, saturating, for the lock length check
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            rel_cnt_q <= '0;
        else if (rel_cnt_q != LOCK_FULL)
            rel_cnt_q <= rel_cnt_q + 1'b1;
    end

    assign below_own = own_sel - 1'b1;
    default clocking cb @(posedge ref_clk); endclocking
    sequence s_run_start;
        $rose(core_run);
    endsequence
    sequence s_fetch;
        fetch_start && (fetch_addr == RESET_VECTOR);
    endsequence
    property p_lock_len;
        disable iff (!rst_b) s_run_start |-> rel_cnt_q == LOCK_FULL;
    endproperty
    a_lock_len: assert property (p_lock_len)
        else $error("core left lock wait at wrong cycle");
    property p_fetch;
        disable iff (!rst_b) s_run_start |-> s_fetch ##1 !fetch_start;
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("no single fetch pulse at run start");
    property p_reset_out;
        !rst_b |=> !core_reset_drive_b;
    endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("reset out high while reset held");
    property p_reset_follow;
        disable iff (!rst_b) core_reset_drive_b == core_run;
    endproperty
    a_reset_follow: assert property (p_reset_follow)
        else $error("reset out does not follow core state");
    property p_own_only;
        disable iff (!rst_b)
            (bus_request_lines_drv.enable & ~own_sel) == '0;
    endproperty
    a_own_only: assert property (p_own_only)
        else $error("driving a line that is not our own");
    property p_decode;
        disable iff (!rst_b) core_run && index_q == bus_req_pkg::INDEX_FIRST
            |-> bus_request_lines_drv.enable == 4'h1;
    endproperty
    a_decode: assert property (p_decode)
        else $error("index one does not drive line one");
    property p_fixed;
        disable iff (!rst_b) $rose(bus_grant) && !solo
            && !$past(rotating_priority_select)
            |-> ($past(req_vec) & below_own) == '0;
    endproperty
    a_fixed: assert property (p_fixed)
        else $error("fixed grant taken over a lower line");
    property p_grant_cause;
        disable iff (!rst_b) bus_grant |-> $past(core_bus_req)
            && $past(core_run);
    endproperty
    a_grant_cause: assert property (p_grant_cause)
        else $error("grant without request");
    property p_lock_quiet;
        disable iff (!rst_b) !core_run |->
            bus_request_lines_drv.enable == '0 && !core_reset_drive_b
            && !bus_grant;
    endproperty
    a_lock_quiet: assert property (p_lock_quiet)
        else $error("activity during lock wait");

endmodule : multiproc_bus_request_reset

// ---- shared/bus_req_pkg.sv ----
package bus_req_pkg;

    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int LINE_COUNT  = 4;
    localparam int INDEX_W     = 3;
    localparam int BOOT_W      = 2;
    localparam int LINE_W      = 2;

    // ****************************************************************
    // timing: pll lock wait, counted in ref_clk cycles
    // ****************************************************************
    localparam int LOCK_CYCLES = 4096;

    // ****************************************************************
    // processor_index codes
    // ****************************************************************
    localparam logic [INDEX_W-1:0] INDEX_SOLO  = 3'h0;
    localparam logic [INDEX_W-1:0] INDEX_FIRST = 3'h1;

    // ****************************************************************
    // reset vector and pin idle levels
    // ****************************************************************
    localparam logic [31:0] RESET_VECTOR_DEFAULT = 32'h0009_0000;
    localparam logic [LINE_COUNT-1:0] LINES_IDLE = 4'hf;
    localparam logic [LINE_COUNT-1:0] LINES_OFF  = 4'h0;
    localparam logic [LINE_W-1:0]     PTR_FIRST  = 2'h0;

    typedef enum {ST_LOCK, ST_RUN} phase_t;

    // own request pin drive: level is the pin value, enable is oe
    typedef struct packed {
        logic [LINE_COUNT-1:0] level;
        logic [LINE_COUNT-1:0] enable;
    } line_drive_t;

endpackage : bus_req_pkg

// ---- tb/other_processors.sv ----
`timescale 1ns/1ns
// ****************************************************************
// other bus masters sharing the request wires
// ****************************************************************
module other_processors (
    input  wire logic       ref_clk,
    input  wire logic [3:0] hold,
    input  wire logic [3:0] own_line,
    output logic      [3:0] lines_out
);
    initial lines_out = 4'hf;
    // released lines read 1 through the pull-up, never a stale low
    // the device's own line is never touched by the others
    always @(posedge ref_clk)
    begin
        lines_out <= ~(hold & ~own_line);
    end
endmodule : other_processors

// ---- tb/multiproc_bus_request_reset_tb.sv ----
`timescale 1ns/1ns
module multiproc_bus_request_reset_tb;
    localparam int          LOCK = 8;
    localparam logic [31:0] VEC  = 32'h0000_0100;
    logic                     ref_clk    = 1'b0;
    logic                     rst_b      = 1'b0;
    logic [1:0]               boot_sel   = 2'h0;
    logic [2:0]               idx        = 3'h1;
    logic                     rot        = 1'b0;
    logic                     req        = 1'b0;
    logic [3:0]               other_hold = 4'h0;
    logic [3:0]               other_lines;
    logic [3:0]               wire_lines;
    bus_req_pkg::line_drive_t drv;
    logic                     grant;
    logic                     rdrv_b;
    logic                     run;
    logic                     fstart;
    logic [31:0]              faddr;
    logic [1:0]               bmode;
    int                       err_count   = 0;
    int                       check_count = 0;

    always #50 ref_clk = ~ref_clk;
    // wired-and with pull-up: any enabled low driver wins
    assign wire_lines = other_lines & (~drv.enable | drv.level);

    function automatic logic [3:0] own_mask(input logic [2:0] id);
        own_mask = (id >= 3'h1 && id <= 3'h4) ? 4'h1 << (id - 3'h1) : 4'h0;
    endfunction : own_mask

    multiproc_bus_request_reset #(.LOCK_CYCLES(LOCK), .RESET_VECTOR(VEC))
    u_multiproc_bus_request_reset (
        .ref_clk(ref_clk), .rst_b(rst_b), .boot_mode_select(boot_sel),
        .processor_index(idx), .rotating_priority_select(rot),
        .bus_request_lines_in(wire_lines), .bus_request_lines_drv(drv),
        .core_bus_req(req), .bus_grant(grant), .core_reset_drive_b(rdrv_b),
        .core_run(run), .fetch_start(fstart), .fetch_addr(faddr),
        .boot_mode(bmode)
    );
    other_processors u_other_processors (
        .ref_clk(ref_clk), .hold(other_hold), .own_line(own_mask(idx)),
        .lines_out(other_lines)
    );

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
            err_count++;
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    task automatic wait_grant(input logic exp, input int lim);
        int n;
        n = 0;
        while (grant !== exp && n < lim)
        begin
            step(1);
            n++;
        end
        chk("bus_grant", {31'h0, exp}, {31'h0, grant});
    endtask : wait_grant

    // straps set while reset is held, index only changes here
    task automatic boot(input logic [2:0] id, input logic [1:0] bm);
        int n;
        n = 0;
        other_hold = 4'h0;
        req = 1'b0;
        rst_b = 1'b0;
        idx = id;
        boot_sel = bm;
        step(2);
        rst_b = 1'b1;
        boot_sel = ~bm;
        while (run !== 1'b1 && n < 100)
        begin
            step(1);
            n++;
            if (run !== 1'b1)
            begin
                chk("own enable", 32'h0, {28'h0, drv.enable});
                chk("reset out", 32'h0, {31'h0, rdrv_b});
            end
        end
        chk("lock cycles", LOCK, n);
        chk("fetch start", 32'h1, {31'h0, fstart});
        chk("fetch addr", VEC, faddr);
        chk("reset out", 32'h1, {31'h0, rdrv_b});
        chk("boot mode", {30'h0, bm}, {30'h0, bmode});
        step(1);
        chk("fetch start", 32'h0, {31'h0, fstart});
    endtask : boot

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_walk();
        boot(3'h1, 2'h1);
        req = 1'b1;
        step(1);
        chk("own enable", 32'h1, {28'h0, drv.enable});
        chk("own level", 32'he, {28'h0, drv.level});
        step(1);
        chk("bus_grant", 32'h1, {31'h0, grant});
        req = 1'b0;
        wait_grant(1'b0, 4);
        chk("own level", 32'hf, {28'h0, drv.level});
        $display("test walk done");
    endtask : t_walk

    task automatic t_blocked();
        boot(3'h2, 2'h2);
        other_hold = 4'h1;
        step(1);
        req = 1'b1;
        step(1);
        chk("own enable", 32'h2, {28'h0, drv.enable});
        chk("own level", 32'hd, {28'h0, drv.level});
        step(5);
        chk("bus_grant", 32'h0, {31'h0, grant});
        other_hold = 4'h0;
        wait_grant(1'b1, 4);
        req = 1'b0;
        wait_grant(1'b0, 4);
        $display("test blocked done");
    endtask : t_blocked

    // line 2 masters, line 1 and ours (line 3) wait for its release
    task automatic t_priority(input logic r);
        rot = r;
        boot(3'h3, 2'h3);
        other_hold = 4'h2;
        step(2);
        other_hold = 4'h3;
        req = 1'b1;
        step(2);
        other_hold = 4'h1;
        if (r)
            wait_grant(1'b1, 6);
        else
        begin
            step(6);
            chk("bus_grant", 32'h0, {31'h0, grant});
        end
        req = 1'b0;
        other_hold = 4'h0;
        step(3);
        $display("test priority %0d done", r);
    endtask : t_priority

    task automatic t_odd_index();
        boot(3'h0, 2'h2);
        req = 1'b1;
        step(2);
        chk("own enable", 32'h0, {28'h0, drv.enable});
        chk("bus_grant", 32'h1, {31'h0, grant});
        req = 1'b0;
        wait_grant(1'b0, 4);
        boot(3'h5, 2'h1);
        req = 1'b1;
        step(4);
        chk("own enable", 32'h0, {28'h0, drv.enable});
        chk("bus_grant", 32'h0, {31'h0, grant});
        req = 1'b0;
        $display("test odd index done");
    endtask : t_odd_index

    // ****************************************************************
    // run control
    // ****************************************************************
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    initial
    begin
        #(20000 * 100);
        err_count++;
        $display("watchdog expired");
        stop_test();
    end

    initial
    begin
        t_walk();
        t_blocked();
        t_priority(1'b0);
        t_priority(1'b1);
        t_odd_index();
        stop_test();
    end
endmodule : multiproc_bus_request_reset_tb
